// File: hdl/tmr16_pkg.sv
// constants and carrier types for the 16-bit timer register block
// assumes a classic wishbone slave port with byte data in lane 0
`default_nettype none
package tmr16_pkg;
    // word-aligned byte addresses of the register map
    localparam logic [7:0] TMR16_A_CTRL1 = 8'h00;
    localparam logic [7:0] TMR16_A_CTRL2 = 8'h04;
    localparam logic [7:0] TMR16_A_FORCE = 8'h08;
    localparam logic [7:0] TMR16_A_CNT_L = 8'h0c;
    localparam logic [7:0] TMR16_A_CNT_H = 8'h10;
    localparam logic [7:0] TMR16_A_OCA_L = 8'h14;
    localparam logic [7:0] TMR16_A_OCA_H = 8'h18;
    localparam logic [7:0] TMR16_A_OCB_L = 8'h1c;
    localparam logic [7:0] TMR16_A_OCB_H = 8'h20;
    localparam logic [7:0] TMR16_A_OCC_L = 8'h24;
    localparam logic [7:0] TMR16_A_OCC_H = 8'h28;
    localparam logic [7:0] TMR16_A_CAP_L = 8'h2c;
    localparam logic [7:0] TMR16_A_CAP_H = 8'h30;
    localparam logic [7:0] TMR16_A_FLAGS = 8'h34;
    // reset values
    localparam logic [7:0] TMR16_RST_BYTE = 8'h00;
    localparam logic [15:0] TMR16_RST_WORD = 16'h0000;
    // flag bit positions
    localparam int TMR16_F_TOV = 0;
    localparam int TMR16_F_OCA = 1;
    localparam int TMR16_F_CAP = 5;
    // filter length and prescaler width
    localparam int TMR16_FILT_LEN = 4;
    localparam int TMR16_PRE_W = 10;
    // clock source codes
    localparam logic [2:0] TMR16_CS_STOP = 3'h0;
    localparam logic [2:0] TMR16_CS_DIV1 = 3'h1;
    localparam logic [2:0] TMR16_CS_DIV8 = 3'h2;
    localparam logic [2:0] TMR16_CS_DIV64 = 3'h3;
    localparam logic [2:0] TMR16_CS_DIV256 = 3'h4;
    localparam logic [2:0] TMR16_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TMR16_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TMR16_CS_EXT_RISE = 3'h7;
    // compare output actions
    localparam logic [1:0] TMR16_ACT_OFF = 2'h0;
    localparam logic [1:0] TMR16_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TMR16_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TMR16_ACT_SET = 2'h3;

    typedef struct packed {
        logic capture_filter_enable;
        logic capture_edge_select;
        logic reserved;
        logic [1:0] wave_hi;
        logic [2:0] clock_source_field;
    } tmr16_ctrl2_t;

    typedef struct packed {
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [1:0] act_c;
        logic [1:0] wave_lo;
    } tmr16_ctrl1_t;
endpackage : tmr16_pkg
`default_nettype wire

// File: hdl/tmr16_regs.sv
// 16-bit timer: control, counter, compare and capture registers
// assumes a classic wishbone master on the core clock; pins are asynchronous
`default_nettype none
// How it works
// - filter output changes only after four equal capture pin samples
// - filter adds exactly four clock cycles to the capture path
// - edge select zero picks falling edge, one picks rising edge
// - capture copies counter into capture register and sets capture flag
// - modes using capture register as top disconnect the capture pin
// - clock code 000 stops; 001-101 divide by 1, 8, 64, 256, 1024
// - code 110 counts external falling edges, 111 rising edges
// - external pin counts even when driven as an output
// - force strobes act only in non-pwm modes
// - force applies the channel's compare action to its pin at once
// - force sets no flag and never clears the counter
// - force bits are strobes and read back zero
// - counter is two byte locations joined through the temporary register
// - one temporary high byte is shared by all 16-bit registers
// - a counter write blocks compare matches on the next timer tick
// - each compare register is compared with the counter every tick
// - compare writes update both bytes in one cycle via temporary byte
// - non-pwm actions: 00 off, 01 toggle, 10 clear, 11 set
// - capture flag clears on vector acknowledge or written one
module tmr16_regs
    import tmr16_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // pins
    input wire logic i_capture_input_pin,
    input wire logic i_external_count_pin,
    output logic [2:0] o_compare_output_pin,
    output logic [2:0] o_compare_output_oe,
    // flag side band
    input wire logic i_capture_vector_ack,
    output logic [5:0] o_flags
);
    logic rst_s1_r;
    logic rst_n_s;
    logic ack_r;
    logic acc;
    logic wr;
    logic rd;
    logic [7:0] wdat;
    logic [7:0] rd_val;
    logic [31:0] rdat_r;
    tmr16_ctrl1_t ctrl1_r;
    tmr16_ctrl2_t ctrl2_r;
    logic [3:0] mode;
    logic nonpwm;
    logic icr_top;
    logic [15:0] top;
    logic [7:0] temp_r;
    logic [15:0] cnt_r;
    logic [15:0] ocr_r [3];
    logic [15:0] icr_r;
    logic [5:0] flags_r;
    logic block_r;
    logic [TMR16_PRE_W-1:0] pre_r;
    logic tick;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_d_r;
    logic cap_s1_r;
    logic cap_s2_r;
    logic [2:0] hist_r;
    logic filt_r;
    logic lvl;
    logic lvl_d_r;
    logic cap_evt;
    logic [2:0] match;
    logic [2:0] frc;
    logic [1:0] act [3];
    logic [2:0] pin_r;

    // reset released through two flops
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_n_s <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_s <= rst_s1_r;
        end
    end

    // one access per request; ack drops the cycle after it was given
    assign acc = i_wb_cyc && i_wb_stb && !ack_r;
    assign wr = acc && i_wb_we && i_wb_sel[0];
    assign rd = acc && !i_wb_we;
    assign wdat = i_wb_dat[7:0];
    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            ack_r <= 1'b0;
        else
            ack_r <= acc;
    end

    // mode decode
    assign mode = {ctrl2_r.wave_hi, ctrl1_r.wave_lo};
    assign nonpwm = (mode == 4'h0) || (mode == 4'h4) || (mode == 4'hc);
    assign icr_top = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he);

    always_comb
    begin
        unique case (mode)
            4'h1, 4'h5: top = 16'h00ff;
            4'h2, 4'h6: top = 16'h01ff;
            4'h3, 4'h7: top = 16'h03ff;
            4'h4, 4'h9, 4'hb, 4'hf: top = ocr_r[0];
            4'h8, 4'ha, 4'hc, 4'he: top = icr_r;
            default: top = 16'hffff;
        endcase
    end

    // control registers
    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            ctrl1_r <= TMR16_RST_BYTE;
            ctrl2_r <= TMR16_RST_BYTE;
        end
        else if (wr)
        begin
            if (i_wb_adr == TMR16_A_CTRL1)
                ctrl1_r <= wdat;
            if (i_wb_adr == TMR16_A_CTRL2)
                ctrl2_r <= {wdat[7:6], 1'b0, wdat[4:0]};
        end
    end

    // shared temporary byte; high write or counter or capture low read loads it
    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            temp_r <= TMR16_RST_BYTE;
        else if (wr && (i_wb_adr == TMR16_A_CNT_H || i_wb_adr == TMR16_A_OCA_H
                 || i_wb_adr == TMR16_A_OCB_H || i_wb_adr == TMR16_A_OCC_H
                 || i_wb_adr == TMR16_A_CAP_H))
            temp_r <= wdat;
        else if (rd && i_wb_adr == TMR16_A_CNT_L)
            temp_r <= cnt_r[15:8];
        else if (rd && i_wb_adr == TMR16_A_CAP_L)
            temp_r <= icr_r[15:8];
    end

    // pin sampled whatever its direction; two flops first
    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_d_r <= 1'b0;
            pre_r <= '0;
        end
        else
        begin
            ext_s1_r <= i_external_count_pin;
            ext_s2_r <= ext_s1_r;
            ext_d_r <= ext_s2_r;
            pre_r <= pre_r + 1'b1;
        end
    end

    always_comb
    begin
        unique case (ctrl2_r.clock_source_field)
            TMR16_CS_STOP: tick = 1'b0;
            TMR16_CS_DIV1: tick = 1'b1;
            TMR16_CS_DIV8: tick = &pre_r[2:0];
            TMR16_CS_DIV64: tick = &pre_r[5:0];
            TMR16_CS_DIV256: tick = &pre_r[7:0];
            TMR16_CS_DIV1024: tick = &pre_r[9:0];
            TMR16_CS_EXT_FALL: tick = ext_d_r && !ext_s2_r;
            TMR16_CS_EXT_RISE: tick = !ext_d_r && ext_s2_r;
        endcase
    end

    // counter written as one word from temp and low byte
    // force strobes never reach the counter, so no clear on force
    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            cnt_r <= TMR16_RST_WORD;
        else if (wr && i_wb_adr == TMR16_A_CNT_L)
            cnt_r <= {temp_r, wdat};
        else if (tick)
            cnt_r <= (cnt_r == top) ? TMR16_RST_WORD : cnt_r + 16'h0001;
    end

    // a counter write masks the next tick's matches
    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            block_r <= 1'b0;
        else if (wr && i_wb_adr == TMR16_A_CNT_L)
            block_r <= 1'b1;
        else if (tick)
            block_r <= 1'b0;
    end

    // compare words commit on the low write
    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            ocr_r[0] <= TMR16_RST_WORD;
            ocr_r[1] <= TMR16_RST_WORD;
            ocr_r[2] <= TMR16_RST_WORD;
        end
        else if (wr)
        begin
            if (i_wb_adr == TMR16_A_OCA_L)
                ocr_r[0] <= {temp_r, wdat};
            if (i_wb_adr == TMR16_A_OCB_L)
                ocr_r[1] <= {temp_r, wdat};
            if (i_wb_adr == TMR16_A_OCC_L)
                ocr_r[2] <= {temp_r, wdat};
        end
    end

    // capture pin synchroniser and filter history
    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            cap_s1_r <= 1'b0;
            cap_s2_r <= 1'b0;
            hist_r <= '0;
            filt_r <= 1'b0;
            lvl_d_r <= 1'b0;
        end
        else
        begin
            cap_s1_r <= i_capture_input_pin;
            cap_s2_r <= cap_s1_r;
            hist_r <= {hist_r[1:0], cap_s2_r};
            // four agreeing samples move the filter output
            if ({hist_r, cap_s2_r} == {TMR16_FILT_LEN{cap_s2_r}})
                filt_r <= cap_s2_r;
            lvl_d_r <= lvl;
        end
    end

    // filtered path trails the raw sample by four clocks
    assign lvl = ctrl2_r.capture_filter_enable ? filt_r : cap_s2_r;
    // edge choice; no capture when capture register is top
    assign cap_evt = !icr_top && (ctrl2_r.capture_edge_select ? (lvl && !lvl_d_r)
                                                              : (!lvl && lvl_d_r));

    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            icr_r <= TMR16_RST_WORD;
        else if (cap_evt)
            icr_r <= cnt_r;
    end

    // strobes only in non-pwm modes; bit 7 is channel a
    assign frc = (wr && i_wb_adr == TMR16_A_FORCE && nonpwm)
                 ? {wdat[5], wdat[6], wdat[7]} : 3'h0;
    assign act[0] = ctrl1_r.act_a;
    assign act[1] = ctrl1_r.act_b;
    assign act[2] = ctrl1_r.act_c;

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_chan
            // compare on every tick; masked after counter write
            assign match[g] = tick && !block_r && (cnt_r == ocr_r[g]);

            always_ff @(posedge i_core_clk or negedge rst_n_s)
            begin
                if (!rst_n_s)
                    pin_r[g] <= 1'b0;
                // match or force applies the channel action
                else if (nonpwm && (match[g] || frc[g]))
                begin
                    unique case (act[g])
                        TMR16_ACT_OFF: pin_r[g] <= pin_r[g];
                        TMR16_ACT_TOGGLE: pin_r[g] <= !pin_r[g];
                        TMR16_ACT_CLEAR: pin_r[g] <= 1'b0;
                        TMR16_ACT_SET: pin_r[g] <= 1'b1;
                    endcase
                end
            end

            // pwm waveforms live elsewhere, so the pin is released there
            assign o_compare_output_oe[g] = nonpwm && (act[g] != TMR16_ACT_OFF);
        end
    endgenerate

    assign o_compare_output_pin = pin_r;

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            flags_r <= '0;
        else
            flags_r <= (flags_r & ~((wr && i_wb_adr == TMR16_A_FLAGS) ? wdat[5:0] : 6'h00)
                        & ~{i_capture_vector_ack, 5'h00})
                       | {cap_evt, 1'b0, match, tick && (cnt_r == top)};
    end

    assign o_flags = flags_r;

    // read mux; force reads zero; high of counter and capture from temp
    always_comb
    begin
        unique case (i_wb_adr)
            TMR16_A_CTRL1: rd_val = ctrl1_r;
            TMR16_A_CTRL2: rd_val = ctrl2_r;
            TMR16_A_CNT_L: rd_val = cnt_r[7:0];
            TMR16_A_CNT_H: rd_val = temp_r;
            TMR16_A_OCA_L: rd_val = ocr_r[0][7:0];
            TMR16_A_OCA_H: rd_val = ocr_r[0][15:8];
            TMR16_A_OCB_L: rd_val = ocr_r[1][7:0];
            TMR16_A_OCB_H: rd_val = ocr_r[1][15:8];
            TMR16_A_OCC_L: rd_val = ocr_r[2][7:0];
            TMR16_A_OCC_H: rd_val = ocr_r[2][15:8];
            TMR16_A_CAP_L: rd_val = icr_r[7:0];
            TMR16_A_CAP_H: rd_val = temp_r;
            TMR16_A_FLAGS: rd_val = {2'h0, flags_r};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            rdat_r <= '0;
        else if (rd)
            rdat_r <= {24'h000000, rd_val};
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_n_s);

    a_filter_agree: assert property ($changed(filt_r) |->
        $past(cap_s2_r, 1) == filt_r && $past(cap_s2_r, 2) == filt_r
        && $past(cap_s2_r, 3) == filt_r && $past(cap_s2_r, 4) == filt_r)
        else $error("filter moved without four agreeing samples");
    a_filter_lag: assert property ($rose(cap_s2_r) ##1 cap_s2_r[*3] |->
        ##1 filt_r)
        else $error("filter output not four clocks behind");
    a_capture_copy: assert property (cap_evt |=>
        icr_r == $past(cnt_r) && flags_r[TMR16_F_CAP])
        else $error("capture did not copy counter and set flag");
    a_capture_edge: assert property (cap_evt |->
        lvl == ctrl2_r.capture_edge_select)
        else $error("capture on the wrong edge");
    a_capture_off: assert property (icr_top |=> icr_r == $past(icr_r))
        else $error("capture while capture register is top");
    a_stop_clock: assert property (ctrl2_r.clock_source_field == TMR16_CS_STOP
        && !(wr && i_wb_adr == TMR16_A_CNT_L) |=> $stable(cnt_r))
        else $error("stopped counter moved");
    a_ext_rise: assert property (ctrl2_r.clock_source_field == TMR16_CS_EXT_RISE
        && $rose(ext_s2_r) |-> tick)
        else $error("external rising edge did not count");
    a_force_pwm: assert property (!nonpwm |=> pin_r == $past(pin_r))
        else $error("force acted in a pwm mode");
    a_force_noflag: assert property (frc[0] && !match[0] |=>
        flags_r[TMR16_F_OCA] == $past(flags_r[TMR16_F_OCA]))
        else $error("force set a compare flag");
    a_force_read: assert property (rd && i_wb_adr == TMR16_A_FORCE |=>
        o_wb_ack && o_wb_dat == 32'h00000000)
        else $error("force register read nonzero");
    a_match_block: assert property (block_r && tick |=>
        (flags_r[3:1] & ~$past(flags_r[3:1])) == 3'h0)
        else $error("match not blocked after counter write");
    a_temp_latch: assert property (rd && i_wb_adr == TMR16_A_CNT_L |=>
        temp_r == $past(cnt_r[15:8]))
        else $error("low read did not latch high byte");

    c_capture: cover property (cap_evt);
    c_force: cover property (frc != 3'h0 ##1 $changed(pin_r));
    c_ext_count: cover property (ctrl2_r.clock_source_field == TMR16_CS_EXT_FALL && tick);
    c_blocked: cover property (block_r && tick && cnt_r == ocr_r[0]);
endmodule : tmr16_regs
`default_nettype wire

// File: verification/tb_timer16_control_compare_regs.sv
// self-checking bench for the 16-bit timer register block
// assumes the pin partner model and a wishbone slave of any ack latency
`default_nettype none
module tb_timer16_control_compare_regs
    import tmr16_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, vack = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, cap_pin, ext_pin;
    logic [2:0] pin, oe;
    logic [5:0] flags;
    logic [31:0] seed = 32'd92;
    logic [7:0] rd;
    logic [15:0] v, c0, c1;
    logic [15:0] cv [3];
    int error_cnt = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    tmr16_regs dut_u (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_capture_input_pin(cap_pin),
        .i_external_count_pin(ext_pin), .o_compare_output_pin(pin),
        .o_compare_output_oe(oe), .i_capture_vector_ack(vack), .o_flags(flags)
    );
    tmr16_pin_model pins_u (.i_core_clk(clk), .o_cap_pin(cap_pin), .o_ext_pin(ext_pin));

    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : xs

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t %s got %h want %h", $time, m, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // one classic cycle; no latency assumed, only the bench timeout ends a wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do
        begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    // high byte goes to the shared temporary byte, low byte commits
    task automatic wr16(input logic [7:0] al, input logic [15:0] d);
        bus(1'b1, al + 8'h04, d[15:8]);
        bus(1'b1, al, d[7:0]);
    endtask : wr16

    task automatic rd16(input logic [7:0] al, output logic [15:0] d);
        bus(1'b0, al, 8'h00);
        d[7:0] = rd;
        bus(1'b0, al + 8'h04, 8'h00);
        d[15:8] = rd;
    endtask : rd16

    task automatic cap_run(input logic [7:0] c2, input logic lvl, output logic [15:0] cap);
        bus(1'b1, TMR16_A_CTRL2, c2);
        bus(1'b1, TMR16_A_FLAGS, 8'h2f);
        wr16(TMR16_A_CNT_L, 16'h0000);
        pins_u.set_cap(lvl);
        repeat (12) @(posedge clk);
        rd16(TMR16_A_CAP_L, cap);
    endtask : cap_run

    initial
    begin
        // tests take about 12k cycles; the slowest prescaler dominates
        #300000;
        error_cnt++;
        close_out();
    end

    initial
    begin
        int div;
        int n;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 0; a < 64; a += 4)
        begin
            bus(1'b0, 8'(a), 8'h00);
            check(rd, 8'h00, "reset");
        end
        v = xs();
        bus(1'b1, TMR16_A_CTRL2, {v[7:6], 1'b0, v[4:3], 3'h0});
        bus(1'b0, TMR16_A_CTRL2, 8'h00);
        check(rd, {v[7:6], 1'b0, v[4:3], 3'h0}, "ctrl2");
        $display("done reset");
        for (int i = 0; i < 3; i++)
        begin
            cv[i] = xs();
            wr16(TMR16_A_OCA_L + 8'(8 * i), cv[i]);
        end
        for (int i = 0; i < 3; i++)
        begin
            rd16(TMR16_A_OCA_L + 8'(8 * i), v);
            check(v, cv[i], "cmp");
        end
        bus(1'b1, TMR16_A_OCA_H, 8'h5a);
        bus(1'b1, TMR16_A_OCB_L, 8'h3c);
        rd16(TMR16_A_OCB_L, v);
        check(v, 16'h5a3c, "temp");
        v = xs();
        bus(1'b1, TMR16_A_CTRL2, 8'h00);
        wr16(TMR16_A_CNT_L, v);
        repeat (20) @(posedge clk);
        rd16(TMR16_A_CNT_L, c0);
        check(c0, v, "cnt");
        $display("done regs");
        for (int k = 1; k < 6; k++)
        begin
            div = (k == 1) ? 1 : (k == 2) ? 8 : (k == 3) ? 64 : (k == 4) ? 256 : 1024;
            wr16(TMR16_A_CNT_L, 16'h0000);
            bus(1'b1, TMR16_A_CTRL2, 8'(k));
            repeat (8 * div) @(posedge clk);
            bus(1'b1, TMR16_A_CTRL2, 8'h00);
            rd16(TMR16_A_CNT_L, v);
            check(16'(v >= 7 && v <= 12), 16'h0001, "div");
        end
        for (int k = 6; k < 8; k++)
        begin
            n = 3 + int'(xs() % 6);
            wr16(TMR16_A_CNT_L, 16'h0000);
            bus(1'b1, TMR16_A_CTRL2, 8'(k));
            pins_u.ext_pulses(n, k - 4);
            repeat (6) @(posedge clk);
            bus(1'b1, TMR16_A_CTRL2, 8'h00);
            rd16(TMR16_A_CNT_L, v);
            check(v, 16'(n), "ext");
        end
        $display("done clocks");
        cap_run(8'h41, 1'b1, c0);
        check(flags[5], 1'b1, "cap");
        check(16'(c0 >= 3 && c0 <= 9), 16'h0001, "capv");
        @(posedge clk);
        vack <= 1'b1;
        @(posedge clk);
        vack <= 1'b0;
        repeat (2) @(posedge clk);
        check(flags[5], 1'b0, "vack");
        cap_run(8'h41, 1'b0, v);
        check(flags[5], 1'b0, "edge");
        cap_run(8'hc1, 1'b1, c1);
        check(c1 - c0, 16'h0004, "filt");
        cap_run(8'h01, 1'b0, c0);
        check(flags[5], 1'b1, "fall");
        bus(1'b1, TMR16_A_FLAGS, 8'h20);
        repeat (2) @(posedge clk);
        check(flags[5], 1'b0, "w1c");
        cap_run(8'h58, 1'b1, v);
        check(flags[5], 1'b0, "topoff");
        check(v, c0, "topval");
        $display("done capture");
        bus(1'b1, TMR16_A_CTRL2, 8'h08);
        bus(1'b1, TMR16_A_CTRL1, 8'he4);
        wr16(TMR16_A_CNT_L, 16'h1234);
        bus(1'b1, TMR16_A_FLAGS, 8'h2f);
        bus(1'b1, TMR16_A_FORCE, 8'he0);
        repeat (2) @(posedge clk);
        check(oe, 3'h7, "oe");
        check(pin, 3'h5, "force");
        check(flags[3:1], 3'h0, "fflag");
        bus(1'b0, TMR16_A_FORCE, 8'h00);
        check(rd, 8'h00, "frd");
        bus(1'b1, TMR16_A_FORCE, 8'h20);
        repeat (2) @(posedge clk);
        check(pin, 3'h1, "tgl");
        rd16(TMR16_A_CNT_L, v);
        check(v, 16'h1234, "noclr");
        bus(1'b1, TMR16_A_CTRL1, 8'h55);
        // software owes zeros here; ones are sent to see them dropped
        bus(1'b1, TMR16_A_FORCE, 8'he0);
        repeat (2) @(posedge clk);
        check(pin, 3'h1, "pwm");
        check(oe, 3'h0, "pwmoe");
        $display("done force");
        bus(1'b1, TMR16_A_CTRL1, 8'h40);
        bus(1'b1, TMR16_A_CTRL2, 8'h00);
        wr16(TMR16_A_OCB_L, 16'hffff);
        wr16(TMR16_A_OCC_L, 16'hffff);
        wr16(TMR16_A_OCA_L, 16'h1000);
        wr16(TMR16_A_CNT_L, 16'h1000);
        bus(1'b1, TMR16_A_FLAGS, 8'h2f);
        bus(1'b1, TMR16_A_CTRL2, 8'h01);
        repeat (20) @(posedge clk);
        check(flags[1], 1'b0, "blk");
        check(pin[0], 1'b1, "blkpin");
        bus(1'b1, TMR16_A_CTRL2, 8'h00);
        wr16(TMR16_A_CNT_L, 16'h0ff0);
        bus(1'b1, TMR16_A_CTRL2, 8'h01);
        repeat (30) @(posedge clk);
        check(flags[1], 1'b1, "match");
        check(pin[0], 1'b0, "mpin");
        $display("done match");
        close_out();
    end
endmodule : tb_timer16_control_compare_regs
`default_nettype wire

// File: verification/tmr16_pin_model.sv
// partner model: the pins that drive the timer's capture and count inputs
// assumes the bench calls its tasks from the core clock domain
`default_nettype none
module tmr16_pin_model (
    // clock
    input wire logic i_core_clk,
    // pins toward the timer
    output logic o_cap_pin,
    output logic o_ext_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_cap_pin = 1'b0;
        o_ext_pin = 1'b0;
    end

    task automatic set_cap(input logic lvl);
        @(posedge i_core_clk);
        o_cap_pin <= lvl;
    endtask : set_cap

    // pin driven like a port output
    // hold sets the pace: short holds test a prompt source, long ones a slow one
    task automatic ext_pulses(input int n, input int hold);
        repeat (2 * n)
        begin
            repeat (hold) @(posedge i_core_clk);
            o_ext_pin <= ~o_ext_pin;
        end
    endtask : ext_pulses
endmodule : tmr16_pin_model
`default_nettype wire
